// [rtl/iss_consts.svh]
// Offsets, field positions, reset values and codes of the slave status block
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH

// Register offsets on the plain register port
`define ISS_OFS_STATUS   8'h00
`define ISS_OFS_CONTROL  8'h04

// Status field positions
`define ISS_BIT_ADDRESSED  14
`define ISS_BIT_REP_START  13
`define ISS_POS_ID_INDEX   11
`define ISS_BIT_STOP_SS    10
`define ISS_POS_GC_KIND    8
`define ISS_BIT_GC_FLAG    7
`define ISS_BIT_BUSY       6
`define ISS_BIT_NACK       5
`define ISS_BIT_RX_OVF     4

// Control field positions
`define ISS_BIT_GC_ENABLE   0
`define ISS_BIT_FORCE_NACK  1
`define ISS_BIT_STOP_IRQ_EN 2
`define ISS_BIT_GC_CLEAR    3

// Reset values
`define ISS_RST_STATUS   16'h0000
`define ISS_RST_CONTROL  3'h0

// Bus codes
`define ISS_START_BYTE   8'h01
`define ISS_GC_ADDR      8'h00
`define ISS_GC_RESET     8'h06
`define ISS_GC_PROGRAM   8'h04

// General-call kind codes
`define ISS_GCK_NONE     2'h0
`define ISS_GCK_RESET    2'h1
`define ISS_GCK_PROGRAM  2'h2
`define ISS_GCK_ALT      2'h3

// Byte length less one
`define ISS_LAST_BIT     3'h7

`endif

// [rtl/iss_pkg.sv]
// Types shared by the slave status block
`default_nettype none
package iss_pkg;

   // Slave status register image, bit 15 down to bit 0
   typedef struct packed {
      logic       rsvd;
      logic       addressed;
      logic       rep_start;
      logic [1:0] id_index;
      logic       stop_ss;
      logic [1:0] gc_kind;
      logic       gc_flag;
      logic       busy;
      logic       nack;
      logic       rx_ovf;
      logic [3:0] low;
   } iss_status_t;

   // Control bits held by this block
   typedef struct packed {
      logic stop_irq_en;
      logic force_nack;
      logic gc_enable;
   } iss_ctl_t;

   // Bus-side sequencer
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b010,
      ST_WDATA = 3'b011,
      ST_WACK  = 3'b100,
      ST_RDATA = 3'b101,
      ST_RACK  = 3'b110
   } iss_state_t;

endpackage : iss_pkg

`default_nettype wire

// [rtl/iss_status.sv]
// I2C slave port: bus event tracking and slave status register
//
// Contract
// R1 - Start then matching address sets addressed flag, bit 14.
// R2 - Start byte 0x01, or enabled general call 0x00, also sets it.
// R3 - Stop condition clears the addressed flag.
// R4 - Repeated start sets bit 13; stop clears it.
// R5 - Bits 12-11 give which of four IDs matched, 00 to 11.
// R6 - Stop after a matched start sets bit 10.
// R7 - Interrupt while bit 10 set and stop interrupt enabled.
// R8 - Any read of the status register clears bit 10.
// R9 - Bits 9:8 give general-call kind: none, reset, program, alternate.
// R10 - General-call reset command leaves the kind field unchanged; the code sets it to reset, 01.
// R11 - Writing general-call clear clears the kind field.
// R12 - Any general-call command sets bit 7.
// R13 - General-call reset returns registers to defaults.
// R14 - Hardware general call leaves its second byte in receive FIFO.
// R15 - Writing general-call clear clears bit 7.
// R16 - Start condition sets busy, bit 6.
// R17 - Busy clears on unmatched address, stop, or unmatched repeat.
// R18 - Bit 5 set when address answered with NACK, else clear.
// R19 - NACK when transmit FIFO empty or force-NACK enabled; the code applies the empty-FIFO NACK to read addresses only.
// R20 - Bit 4 set when byte pushed into full receive FIFO.
// R21 - General calls recognised only while general-call enable set.
// R22 - Data 0x06 means reset plus program, 0x04 program.
// R23 - Bit 15 reads zero; status writes are ignored.
// R24 - Flags update on system clock from synchronised bus events.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "iss_consts.svh"

module iss_status
   import iss_pkg::*;
(
   // Clock and reset
   input  wire logic            clk_sys,
   input  wire logic            arst_n,
   // Register port
   input  wire logic [7:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output var  logic [15:0]     reg_rdata,
   // Bus pins
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output var  logic            sda_out,
   output var  logic            sda_oe_n,
   // Address setup from the ID registers
   input  wire logic [3:0][7:0] slave_id_regs,
   input  wire logic [7:0]      alt_id_reg,
   // FIFO side
   input  wire logic            tx_fifo_empty,
   input  wire logic [7:0]      tx_data,
   output var  logic            tx_pop,
   input  wire logic            rx_fifo_full,
   output var  logic            rx_push,
   output var  logic [7:0]      rx_data,
   // Events to the rest of the port
   output var  logic            stop_irq,
   output var  logic            gc_reset
);

   // Pin synchronisers and previous sample
   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;

   // Sequencer state
   iss_state_t  st_q, st_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d;
   logic        ph_q, ph_d, ack_q, ack_d, rw_q, rw_d, gcm_q, gcm_d;
   logic        drv_q, drv_d, frame_q, push_d, pop_d;
   logic [7:0]  rxd_d;

   // Registers
   iss_status_t sts_q, sts_d;
   iss_ctl_t    ctl_q, ctl_d;
   logic [15:0] rdata_q, rdata_d;
   logic        push_q, pop_q, gcr_q, irq_q;
   logic [7:0]  rxd_q;

   // Synchronise both pins; only the second stage and later are read
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // Bus events on the system clock
   wire start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;  // R24
   wire stop_w  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;  // R24
   wire rise_w  = scl_s_q & ~scl_p_q;
   wire fall_w  = ~scl_s_q & scl_p_q;

   // Byte assembled at the current sampling edge
   wire [7:0] byte_w = {sh_q[6:0], sda_s_q};
   wire       last_w = (cnt_q == `ISS_LAST_BIT);

   // Address compare against the four IDs, 7-bit address in bits 7:1
   logic [3:0] id_hit_w;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_id
         assign id_hit_w[gi] = (byte_w[7:1] == slave_id_regs[gi][7:1]);
      end
   endgenerate

   // Lowest matching ID wins when two IDs are programmed alike
   wire       any_hit_w = |id_hit_w;
   wire [1:0] hit_idx_w = id_hit_w[0] ? 2'h0 :
                          id_hit_w[1] ? 2'h1 :
                          id_hit_w[2] ? 2'h2 : 2'h3;  // R5

   // Address phase decode
   wire addr_done_w = (st_q == ST_ADDR) & rise_w & last_w;
   wire gc_addr_w   = (byte_w == `ISS_GC_ADDR) & ctl_q.gc_enable;  // R21
   wire sbyte_w     = (byte_w == `ISS_START_BYTE);
   wire refuse_w    = ctl_q.force_nack | (byte_w[0] & tx_fifo_empty);  // R19
   wire ack_addr_w  = (any_hit_w & ~refuse_w) | gc_addr_w;
   wire nack_addr_w = any_hit_w & refuse_w;  // R18

   // Data phase decode, first byte after a general-call address
   wire data_done_w = (st_q == ST_WDATA) & rise_w & last_w;
   wire gc_byte_w   = data_done_w & gcm_q;
   wire gc_rst_w    = gc_byte_w & (byte_w == `ISS_GC_RESET);    // R22
   wire gc_prog_w   = gc_byte_w & (byte_w == `ISS_GC_PROGRAM);  // R22
   wire gc_hw_w     = gc_byte_w & byte_w[0];
   wire gc_alt_w    = gc_hw_w & (byte_w[7:1] == alt_id_reg[7:1]);

   // Register port decode
   wire sel_sts_w = (reg_addr == `ISS_OFS_STATUS);
   wire sel_ctl_w = (reg_addr == `ISS_OFS_CONTROL);
   wire rd_sts_w  = reg_rd & sel_sts_w;
   wire wr_ctl_w  = reg_wr & sel_ctl_w;
   wire gc_clr_w  = wr_ctl_w & reg_wdata[`ISS_BIT_GC_CLEAR];

   // Sequencer: address, acknowledge, write data and read data phases
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      ph_d   = ph_q;
      ack_d  = ack_q;
      rw_d   = rw_q;
      gcm_d  = gcm_q;
      drv_d  = drv_q;
      push_d = 1'b0;
      pop_d  = 1'b0;
      rxd_d  = rxd_q;
      if (stop_w) begin
         st_d  = ST_IDLE;
         drv_d = 1'b0;
      end else if (start_w) begin
         st_d  = ST_ADDR;
         cnt_d = 3'h0;
         drv_d = 1'b0;
         gcm_d = 1'b0;
      end else begin
         case (st_q)
            ST_ADDR: begin
               if (rise_w) begin
                  sh_d  = byte_w;
                  cnt_d = cnt_q + 3'h1;
                  if (last_w) begin
                     // Start byte is never acknowledged
                     st_d  = ST_AACK;
                     ph_d  = 1'b0;
                     ack_d = ack_addr_w;  // R19
                     rw_d  = byte_w[0] & any_hit_w;
                     gcm_d = gc_addr_w;
                  end
               end
            end
            ST_AACK, ST_WACK: begin
               if (fall_w) begin
                  if (!ph_q) begin
                     ph_d  = 1'b1;
                     drv_d = ack_q;
                  end else begin
                     drv_d = 1'b0;
                     cnt_d = 3'h0;
                     if (!ack_q) begin
                        st_d = ST_IDLE;
                     end else if (rw_q) begin
                        st_d  = ST_RDATA;
                        sh_d  = tx_data;
                        drv_d = ~tx_data[7];
                        pop_d = 1'b1;
                     end else begin
                        st_d = ST_WDATA;
                     end
                  end
               end
            end
            ST_WDATA: begin
               if (rise_w) begin
                  sh_d  = byte_w;
                  cnt_d = cnt_q + 3'h1;
                  if (last_w) begin
                     // Every data byte, hardware call second byte too
                     push_d = 1'b1;  // R14
                     rxd_d  = byte_w;
                     gcm_d  = 1'b0;
                     st_d   = ST_WACK;
                     ph_d   = 1'b0;
                     ack_d  = 1'b1;
                  end
               end
            end
            ST_RDATA: begin
               if (fall_w) begin
                  if (last_w) begin
                     drv_d = 1'b0;
                     st_d  = ST_RACK;
                     ph_d  = 1'b0;
                  end else begin
                     sh_d  = {sh_q[6:0], 1'b0};
                     drv_d = ~sh_q[6];
                     cnt_d = cnt_q + 3'h1;
                  end
               end
            end
            ST_RACK: begin
               // Master NACK ends the read; ACK fetches the next byte
               if (rise_w) begin
                  ph_d = ~sda_s_q;
                  if (sda_s_q) begin
                     st_d = ST_IDLE;
                  end
               end else if (fall_w && ph_q) begin
                  st_d  = ST_RDATA;
                  cnt_d = 3'h0;
                  sh_d  = tx_data;
                  drv_d = ~tx_data[7];
                  pop_d = 1'b1;
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   // Status flag updates; later assignments take priority
   always_comb begin
      sts_d = sts_q;
      ctl_d = ctl_q;
      if (wr_ctl_w) begin
         ctl_d.gc_enable   = reg_wdata[`ISS_BIT_GC_ENABLE];
         ctl_d.force_nack  = reg_wdata[`ISS_BIT_FORCE_NACK];
         ctl_d.stop_irq_en = reg_wdata[`ISS_BIT_STOP_IRQ_EN];
      end
      if (rd_sts_w) begin
         sts_d.stop_ss = 1'b0;  // R8
      end
      if (gc_clr_w) begin
         sts_d.gc_kind = `ISS_GCK_NONE;  // R11
         sts_d.gc_flag = 1'b0;           // R15
      end
      if (start_w) begin
         sts_d.busy = 1'b1;  // R16
         sts_d.nack = 1'b0;  // R18
         if (frame_q) begin
            sts_d.rep_start = 1'b1;  // R4
         end
      end
      if (addr_done_w) begin
         if (any_hit_w | gc_addr_w | sbyte_w) begin
            sts_d.addressed = 1'b1;  // R1 R2
         end
         if (any_hit_w) begin
            sts_d.id_index = hit_idx_w;  // R5
         end else if (!gc_addr_w) begin
            sts_d.busy = 1'b0;  // R17
         end
         if (nack_addr_w) begin
            sts_d.nack = 1'b1;  // R18
         end
      end
      if (push_d) begin
         sts_d.rx_ovf = rx_fifo_full;  // R20
      end
      if (gc_rst_w) begin
         // Everything to default except the general-call report
         sts_d         = iss_status_t'(`ISS_RST_STATUS);  // R13
         sts_d.gc_kind = `ISS_GCK_RESET;  // R9 R10
         ctl_d         = iss_ctl_t'(`ISS_RST_CONTROL);   // R13
      end
      if (gc_prog_w) begin
         sts_d.gc_kind = `ISS_GCK_PROGRAM;  // R9
      end
      if (gc_alt_w) begin
         sts_d.gc_kind = `ISS_GCK_ALT;  // R9
      end
      if (gc_rst_w | gc_prog_w | gc_hw_w) begin
         sts_d.gc_flag = 1'b1;  // R12
      end
      if (stop_w) begin
         sts_d.addressed = 1'b0;  // R3
         sts_d.rep_start = 1'b0;  // R4
         sts_d.busy      = 1'b0;  // R17
         if (sts_q.addressed) begin
            sts_d.stop_ss = 1'b1;  // R6
         end
      end
      // Set always beats the read clear above
      sts_d.rsvd = 1'b0;  // R23
      sts_d.low  = 4'h0;
   end

   // Read data mux; unmapped offsets read zero, the last answer holds between reads
   wire [15:0] rd_img_w = sel_sts_w ? 16'(sts_q) :  // R23
                          sel_ctl_w ? {13'h0000, ctl_q} : 16'h0000;
   assign rdata_d = reg_rd ? rd_img_w : rdata_q;

   // Sequencer registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q  <= ST_IDLE;
         cnt_q <= 3'h0;
         sh_q  <= 8'h00;
         ph_q  <= 1'b0;
         ack_q <= 1'b0;
         rw_q  <= 1'b0;
         gcm_q <= 1'b0;
         drv_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         ph_q  <= ph_d;
         ack_q <= ack_d;
         rw_q  <= rw_d;
         gcm_q <= gcm_d;
         drv_q <= drv_d;
      end
   end

   // Frame tracking tells a repeated start from a first one
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         frame_q <= 1'b0;
      end else if (stop_w) begin
         frame_q <= 1'b0;
      end else if (start_w) begin
         frame_q <= 1'b1;
      end
   end

   // Status, control and output registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sts_q   <= iss_status_t'(`ISS_RST_STATUS);
         ctl_q   <= iss_ctl_t'(`ISS_RST_CONTROL);
         rdata_q <= 16'h0000;
         push_q  <= 1'b0;
         pop_q   <= 1'b0;
         rxd_q   <= 8'h00;
         gcr_q   <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         sts_q   <= sts_d;
         ctl_q   <= ctl_d;
         rdata_q <= rdata_d;
         push_q  <= push_d;
         pop_q   <= pop_d;
         rxd_q   <= rxd_d;
         gcr_q   <= gc_rst_w;                        // R13
         irq_q   <= sts_d.stop_ss & ctl_d.stop_irq_en;  // R7
      end
   end

   // Open-drain data pin: only ever pulled low
   assign sda_out   = 1'b0;
   assign sda_oe_n  = ~drv_q;
   assign reg_rdata = rdata_q;
   assign tx_pop    = pop_q;
   assign rx_push   = push_q;
   assign rx_data   = rxd_q;
   assign stop_irq  = irq_q;
   assign gc_reset  = gcr_q;

endmodule : iss_status

`default_nettype wire

// [testbench/iss_i2c_master.sv]
// Behavioural bus master driving the slave's clock and data pins
`timescale 1ns/10ps
`default_nettype none

module iss_i2c_master (
   // Pins; data is open drain, so 1 means released
   output var  logic scl,
   output var  logic sda_rel,
   input  wire logic sda_line
);
   // Clock stands high and data released outside frames
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // Start, or repeated start when entered with the clock low
   task automatic start();
      sda_rel = 1'b1;
      #20 scl = 1'b1;
      #20 sda_rel = 1'b0;
      #20 scl = 1'b0;
      #20;
   endtask : start

   task automatic stop();
      #20 sda_rel = 1'b0;
      #20 scl = 1'b1;
      #20 sda_rel = 1'b1;
      #40;
   endtask : stop

   // Byte out MSB first; extra low time after the ack lets the slave let go
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #20 sda_rel = b[i];
         #20 scl = 1'b1;
         #40 scl = 1'b0;
      end
      #20 sda_rel = 1'b1;
      #20 scl = 1'b1;
      #20 ack = !sda_line;
      #20 scl = 1'b0;
      #20;
   endtask : put

   task automatic get(input logic ackm, output logic [7:0] b);
      sda_rel = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #40 scl = 1'b1;
         #20 b[i] = sda_line;
         #20 scl = 1'b0;
      end
      #20 sda_rel = !ackm;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #10 sda_rel = 1'b1;
      #10;
   endtask : get
endmodule : iss_i2c_master

`default_nettype wire

// [testbench/iss_status_assertions.sv]
// Port-level checks of the slave status block
`timescale 1ns/10ps
`default_nettype none

module iss_status_assertions (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        arst_n,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Bus pins and events
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        rx_push,
   input wire logic        stop_irq,
   input wire logic        gc_reset
);
   logic [3:0] idle_q;
   logic [3:0] idle_d;

   // Quiet-bus counter; a stop needs a few cycles to clear the synchroniser
   assign idle_d = !(scl_in && sda_in) ? 4'h0 : (idle_q == 4'hf) ? idle_q : idle_q + 4'h1;
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n) idle_q <= 4'h0;
      else idle_q <= idle_d;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_rsvd_reads_zero: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata[15] == 1'b0 && reg_rdata[3:0] == 4'h0)
      else $error("status reserved bits not zero");
   a_read_clears_stop: assert property (
      reg_rd && reg_addr == 8'h00 && idle_q == 4'hf |=> !stop_irq)
      else $error("status read left stop flag set");
   a_rdata_holds: assert property (
      !reg_rd ##1 !gc_reset |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr != 8'h00 && reg_addr != 8'h04 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_ctl_readback: assert property (
      reg_wr && reg_addr == 8'h04 && idle_q == 4'hf ##2 reg_rd && reg_addr == 8'h04
      |=> reg_rdata == {13'h0000, $past(reg_wdata[2:0], 3)})
      else $error("control readback wrong");
   a_irq_gated: assert property (
      reg_wr && reg_addr == 8'h04 && !reg_wdata[2] |=> !stop_irq)
      else $error("stop interrupt while disabled");
   a_push_single: assert property (
      rx_push |=> !rx_push)
      else $error("receive push longer than one cycle");
   a_gc_reset_ctl: assert property (
      gc_reset |=> !stop_irq)
      else $error("control not defaulted by general-call reset");
   a_irq_idle_steady: assert property (
      idle_q == 4'hf && !reg_wr && !reg_rd |=> $stable(stop_irq))
      else $error("stop interrupt moved on a quiet bus");
endmodule : iss_status_assertions

bind iss_status iss_status_assertions i_iss_status_assertions (
   .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
   .sda_in(sda_in), .rx_push(rx_push), .stop_irq(stop_irq), .gc_reset(gc_reset));

`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the slave status block
`timescale 1ns/10ps
`default_nettype none

module tb;
   import iss_pkg::*;
   logic            clk_sys, arst_n, reg_wr, reg_rd, scl, sda_rel;
   logic            tx_fifo_empty, rx_fifo_full, sda_out, sda_oe_n;
   logic            tx_pop, rx_push, stop_irq, gc_reset, ack;
   logic [7:0]      reg_addr, rx_data, rx_last;
   logic [7:0]      tx_data = 8'h3c;
   logic [7:0]      alt = 8'h5a;
   logic [15:0]     reg_wdata, reg_rdata, d;
   logic [3:0][7:0] ids = {8'h90, 8'h62, 8'h44, 8'h20};
   int              err_count, total_checks, gc_cnt, pop_cnt;
   wire logic       sda_line = sda_rel & (sda_oe_n | sda_out);

   iss_status i_iss_status (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .slave_id_regs(ids), .alt_id_reg(alt), .tx_fifo_empty(tx_fifo_empty),
      .tx_data(tx_data), .tx_pop(tx_pop), .rx_fifo_full(rx_fifo_full), .rx_push(rx_push),
      .rx_data(rx_data), .stop_irq(stop_irq), .gc_reset(gc_reset));
   iss_i2c_master i_iss_i2c_master (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Keep what the slave hands out
   always @(posedge clk_sys) begin
      if (rx_push) rx_last <= rx_data;
      if (gc_reset) gc_cnt++;
      if (tx_pop) pop_cnt++;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      // Return past the edge so bus pins never move on a sampling edge
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Status compared under a mask of the fields in question
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      rd(8'h00);
      chk("status", e, d & m);
   endtask : st

   task automatic adr(input logic [7:0] b);
      i_iss_i2c_master.start();
      i_iss_i2c_master.put(b, ack);
   endtask : adr

   task automatic t_regs();
      // Quiet bus first so the control readback check is armed
      repeat (20) @(posedge clk_sys);
      st(16'hffff, 16'h0000);
      wr(8'h00, 16'hffff);
      st(16'hffff, 16'h0000);
      wr(8'h04, 16'h0007);
      rd(8'h04);
      chk("control", 16'h0007, d);
      wr(8'h04, 16'h0000);
      rd(8'h08);
      chk("unmapped", 16'h0000, d);
   endtask : t_regs

   task automatic t_ids();
      for (int k = 0; k < 4; k++) begin
         adr(ids[k]);
         chk("ack", 16'h0001, {15'h0, ack});
         st(16'h7860, {2'b01, 1'b0, 2'(k), 11'h040});
         i_iss_i2c_master.put(8'ha5 ^ 8'(k), ack);
         i_iss_i2c_master.stop();
         chk("rx byte", {8'h0, 8'ha5 ^ 8'(k)}, {8'h0, rx_last});
         st(16'h6440, 16'h0400);
         st(16'h0400, 16'h0000);
      end
   endtask : t_ids

   task automatic t_rep();
      adr(ids[0]);
      adr(ids[1]);
      st(16'h7840, 16'h6840);
      adr(8'hfe);
      chk("ack", 16'h0000, {15'h0, ack});
      st(16'h0040, 16'h0000);
      i_iss_i2c_master.stop();
      st(16'h2000, 16'h0000);
   endtask : t_rep

   task automatic t_nack();
      logic [7:0] b;
      adr(8'hfe);
      st(16'h4040, 16'h0000);
      i_iss_i2c_master.stop();
      st(16'h0400, 16'h0000);
      wr(8'h04, 16'h0002);
      adr(ids[2]);
      chk("ack", 16'h0000, {15'h0, ack});
      st(16'h0020, 16'h0020);
      i_iss_i2c_master.stop();
      wr(8'h04, 16'h0000);
      adr(ids[3] | 8'h01);
      chk("ack", 16'h0000, {15'h0, ack});
      st(16'h0020, 16'h0020);
      i_iss_i2c_master.stop();
      @(posedge clk_sys) tx_fifo_empty <= 1'b0;
      #1;
      adr(ids[3] | 8'h01);
      chk("ack", 16'h0001, {15'h0, ack});
      st(16'h0020, 16'h0000);
      i_iss_i2c_master.get(1'b0, b);
      chk("read byte", 16'h003c, {8'h0, b});
      chk("tx pops", 16'h0001, 16'(pop_cnt));
      i_iss_i2c_master.stop();
      @(posedge clk_sys) tx_fifo_empty <= 1'b1;
   endtask : t_nack

   task automatic t_ovf();
      rd(8'h00);
      wr(8'h04, 16'h0004);
      chk("stop irq", 16'h0000, {15'h0, stop_irq});
      adr(ids[0]);
      @(posedge clk_sys) rx_fifo_full <= 1'b1;
      #1;
      i_iss_i2c_master.put(8'h11, ack);
      st(16'h0010, 16'h0010);
      @(posedge clk_sys) rx_fifo_full <= 1'b0;
      #1;
      i_iss_i2c_master.put(8'h22, ack);
      st(16'h0010, 16'h0000);
      i_iss_i2c_master.stop();
      // Long quiet bus, so the next status read happens on an idle bus
      #200;
      chk("stop irq", 16'h0001, {15'h0, stop_irq});
      st(16'h0400, 16'h0400);
      chk("stop irq", 16'h0000, {15'h0, stop_irq});
      wr(8'h04, 16'h0000);
   endtask : t_ovf

   task automatic t_gc();
      adr(8'h00);
      chk("ack", 16'h0000, {15'h0, ack});
      st(16'h4080, 16'h0000);
      i_iss_i2c_master.stop();
      wr(8'h04, 16'h0001);
      adr(8'h00);
      chk("ack", 16'h0001, {15'h0, ack});
      st(16'h4000, 16'h4000);
      i_iss_i2c_master.put(8'h04, ack);
      st(16'h0380, 16'h0280);
      i_iss_i2c_master.stop();
      adr(8'h00);
      i_iss_i2c_master.put(8'h06, ack);
      st(16'h0380, 16'h0180);
      chk("gc pulses", 16'h0001, 16'(gc_cnt));
      rd(8'h04);
      chk("control", 16'h0000, d);
      i_iss_i2c_master.stop();
      wr(8'h04, 16'h0009);
      st(16'h0380, 16'h0000);
      adr(8'h00);
      i_iss_i2c_master.put(alt | 8'h01, ack);
      st(16'h0380, 16'h0380);
      chk("rx byte", {8'h0, alt | 8'h01}, {8'h0, rx_last});
      i_iss_i2c_master.stop();
      wr(8'h04, 16'h0000);
      adr(8'h01);
      chk("ack", 16'h0000, {15'h0, ack});
      st(16'h4040, 16'h4000);
      i_iss_i2c_master.stop();
   endtask : t_gc

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // Main sequence: reset for five cycles, then the scenarios
   initial begin
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      tx_fifo_empty = 1'b1;
      rx_fifo_full = 1'b0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_regs();
      t_ids();
      t_rep();
      t_nack();
      t_ovf();
      t_gc();
      results();
   end

   // Watchdog well beyond the expected run of about 24 us
   initial begin
      #300000;
      err_count++;
      results();
   end
endmodule : tb

`default_nettype wire
